// ---- hdl/apd_cfg.svh ----
// constants for the converter serial-frame control block
`ifndef APD_CFG_SVH
`define APD_CFG_SVH
// register offsets
`define APD_OFS_CONFIG      2'h0
`define APD_OFS_REFERENCE   2'h2
// command codes in word bits 15:12
`define APD_CMD_READ_CFG    4'h3
`define APD_CMD_WRITE_CFG   4'h8
`define APD_CMD_REF_FIRST   4'h9
`define APD_CMD_REF_SECOND  4'hA
// configuration field positions
`define APD_BIT_READ_CLK    11
`define APD_BIT_LINE_SEL    10
`define APD_BIT_RANGE       9
`define APD_BIT_NEG_INPUT   7
`define APD_BIT_REF_INT     6
`define APD_BIT_STANDBY     5
`define APD_BIT_FORMAT      4
// reset values
`define APD_CFG_RESET       12'h000
`define APD_REF_RESET       9'h1FF
// falling-edge counts per frame
`define APD_EDGES_DUAL      6'h20
`define APD_EDGES_SINGLE    6'h30
`define APD_EDGE_MSB        6'h10
// wake delay in ns, clock in MHz, derived cycle count rounded up
`define APD_WAKE_NS         1000
`define APD_CLK_MHZ         125
`define APD_WAKE_CYC        ((`APD_WAKE_NS * `APD_CLK_MHZ + 999) / 1000)
`endif

// ---- hdl/apd_frame_ctrl.sv ----
// serial frame, power-down and configuration control of a dual converter
`timescale 1ns/1ns
`include "apd_cfg.svh"
module apd_frame_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_sdi,
  input  wire logic [15:0] i_result_first,
  input  wire logic [15:0] i_result_second,
  output logic             o_serial_out_first,
  output logic             o_serial_out_first_oe_n,
  output logic             o_serial_out_second,
  output logic             o_serial_out_second_oe_n,
  output logic             o_power_down,
  output logic             o_powering_up,
  output logic             o_sample_start,
  output logic             o_standby,
  output logic             o_range_double,
  output logic             o_neg_input_half,
  output logic             o_ref_internal_on,
  output logic [8:0]       o_first_reference_level,
  output logic [8:0]       o_second_reference_level
);
  // ---------------- link side, clocked by the serial clock ----------------
  logic             link_clr;
  logic [5:0]       cnt_q;
  logic [31:0]      sh_q;
  logic [15:0]      sb_q;
  logic             serial_out_first_q;
  logic             serial_out_second_q;
  logic             oe_a_n_q;
  logic             oe_b_n_q;
  apd_pkg::apd_frame_t fr_q;
  logic             pd_s1_q;
  logic             pd_s2_q;
  logic             sgl_s1_q;
  logic             sgl_s2_q;
  logic             rdy_s1_q;
  logic             rdy_s2_q;
  // main-side words seen by the link
  logic [15:0]      hold_a_q;
  logic [15:0]      hold_b_q;
  logic             hold_rdy_q;
  logic             pd_q;
  logic [11:0]      cfg_q;
  // load values for the shifter, zero when the hold word is not ready
  wire  [15:0]      load_a = rdy_s2_q ? hold_a_q : 16'h0000;
  wire  [15:0]      load_b = rdy_s2_q ? hold_b_q : 16'h0000;
  wire              at_msb = (cnt_q == `APD_EDGE_MSB - 6'h01);
  wire              past_msb = (cnt_q >= `APD_EDGE_MSB);
  wire              before_dual_end = (cnt_q < `APD_EDGES_DUAL - 6'h01);
  // drive from the third edge, when the synced power and mode flags are this frame's
  wire              drive_ok = (cnt_q > 6'h01) && !pd_s2_q;

  assign link_clr = i_cs_n | ~i_rst_n;

  // main-side levels brought into the serial clock domain
  always_ff @(negedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_s1_q  <= 1'b0;
      pd_s2_q  <= 1'b0;
      sgl_s1_q <= 1'b0;
      sgl_s2_q <= 1'b0;
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else begin
      pd_s1_q  <= pd_q;
      pd_s2_q  <= pd_s1_q;
      sgl_s1_q <= cfg_q[`APD_BIT_LINE_SEL];
      sgl_s2_q <= sgl_s1_q;
      rdy_s1_q <= hold_rdy_q;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // edge counter and output shifter, cleared whenever chip select is high
  always_ff @(negedge i_sclk or posedge link_clr) begin
    if (link_clr) begin
      cnt_q    <= 6'h00;
      sh_q     <= 32'h0000_0000;
      sb_q     <= 16'h0000;
      serial_out_first_q  <= 1'b0;
      serial_out_second_q  <= 1'b0;
      oe_a_n_q <= 1'b1;
      oe_b_n_q <= 1'b1;
    end else begin
      if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
      oe_a_n_q <= ~drive_ok;
      oe_b_n_q <= ~(drive_ok && !sgl_s2_q);
      if (at_msb) begin
        sh_q    <= {load_a[14:0], load_b, 1'b0};
        sb_q    <= {load_b[14:0], 1'b0};
        serial_out_first_q <= load_a[15];
        serial_out_second_q <= load_b[15];
      end else if (past_msb) begin
        sh_q    <= {sh_q[30:0], 1'b0};
        sb_q    <= {sb_q[14:0], 1'b0};
        serial_out_first_q <= sh_q[31] & (sgl_s2_q | before_dual_end);
        serial_out_second_q <= sb_q[15];
      end
    end
  end

  // frame record kept past chip-select rise for the main side to read
  always_ff @(negedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fr_q <= '0;
    end else if (cnt_q == 6'h00) begin
      fr_q.word         <= {15'h0000, i_sdi};
      fr_q.high_run     <= i_sdi;
      fr_q.low_run      <= ~i_sdi;
      fr_q.reach_dual   <= 1'b0;
      fr_q.reach_single <= 1'b0;
    end else begin
      if (cnt_q < `APD_EDGE_MSB) fr_q.word <= {fr_q.word[14:0], i_sdi};
      if (cnt_q < `APD_EDGES_SINGLE) begin
        fr_q.high_run <= fr_q.high_run & i_sdi;
        fr_q.low_run  <= fr_q.low_run & ~i_sdi;
      end
      if (cnt_q == `APD_EDGES_DUAL - 6'h01) fr_q.reach_dual <= 1'b1;
      if (cnt_q == `APD_EDGES_SINGLE - 6'h01) fr_q.reach_single <= 1'b1;
    end
  end

  assign o_serial_out_first       = serial_out_first_q;
  assign o_serial_out_second      = serial_out_second_q;
  assign o_serial_out_first_oe_n  = oe_a_n_q;
  assign o_serial_out_second_oe_n = oe_b_n_q;

  // ---------------- main side, clocked by i_clk ----------------
  localparam logic [15:0] WAKE_CYC = 16'(`APD_WAKE_CYC);
  apd_pkg::apd_state_t state_q;
  logic             cs_s1_q;
  logic             cs_s2_q;
  logic             cs_s3_q;
  logic             stby_q;
  logic             rdbk_q;
  logic             wake_q;
  logic             smp_q;
  logic [8:0]       ref1_q;
  logic [8:0]       ref2_q;
  logic [15:0]      wcnt_q;

  // frame edges, decode and result formatting
  wire              frame_end   = cs_s2_q & ~cs_s3_q;
  wire              frame_start = ~cs_s2_q & cs_s3_q;
  wire              single      = cfg_q[`APD_BIT_LINE_SEL];
  wire              frame_ok    = single ? fr_q.reach_single : fr_q.reach_dual;
  wire              go_down     = fr_q.reach_single & fr_q.high_run;
  wire              go_up       = fr_q.reach_single & fr_q.low_run;
  wire  [3:0]       cmd         = fr_q.word[15:12];
  wire              active_end  = frame_end && (state_q == apd_pkg::APD_ACTIVE);
  wire              take_word   = active_end && frame_ok && !go_down;
  wire              wr_cfg      = take_word && (cmd == `APD_CMD_WRITE_CFG);
  wire              rd_cfg      = take_word && (cmd == `APD_CMD_READ_CFG);
  wire              wr_ref1     = take_word && (cmd == `APD_CMD_REF_FIRST);
  wire              wr_ref2     = take_word && (cmd == `APD_CMD_REF_SECOND);
  wire              fmt_twos    = cfg_q[`APD_BIT_FORMAT];
  wire  [15:0]      res_a       = {i_result_first[15] ^ fmt_twos, i_result_first[14:0]};
  wire  [15:0]      res_b       = {i_result_second[15] ^ fmt_twos, i_result_second[14:0]};
  wire  [15:0]      cfg_word    = {4'h0, cfg_q[11:6], 1'b0, cfg_q[4:0]};
  wire              wake_done   = (wcnt_q == WAKE_CYC - 16'h0001);

  // chip select synchroniser and edge detect
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else if (i_ce) begin
      cs_s1_q <= i_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // result hold words, captured at frame start, released at frame end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_a_q   <= 16'h0000;
      hold_b_q   <= 16'h0000;
      hold_rdy_q <= 1'b0;
    end else if (i_ce) begin
      if (frame_start) begin
        hold_a_q   <= rdbk_q ? cfg_word : res_a;
        hold_b_q   <= res_b;
        hold_rdy_q <= 1'b1;
      end else if (frame_end) begin
        hold_rdy_q <= 1'b0;
      end
    end
  end

  // power state sequencing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= apd_pkg::APD_ACTIVE;
      pd_q    <= 1'b0;
      wake_q  <= 1'b0;
      wcnt_q  <= 16'h0000;
    end else if (i_ce) begin
      unique case (state_q)
        apd_pkg::APD_ACTIVE: begin
          if (active_end && go_down) begin
            state_q <= apd_pkg::APD_OFF;
            pd_q    <= 1'b1;
          end
        end
        apd_pkg::APD_OFF: begin
          if (frame_end && go_up) begin
            state_q <= apd_pkg::APD_WAKING;
            pd_q    <= 1'b0;
            wake_q  <= 1'b1;
            wcnt_q  <= 16'h0000;
          end
        end
        apd_pkg::APD_WAKING: begin
          wcnt_q <= wcnt_q + 16'h0001;
          if (wake_done) begin
            state_q <= apd_pkg::APD_ACTIVE;
            wake_q  <= 1'b0;
          end
        end
      endcase
    end
  end

  // configuration and reference registers, written only by valid frames
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q  <= `APD_CFG_RESET;
      stby_q <= 1'b0;
      rdbk_q <= 1'b0;
      ref1_q <= `APD_REF_RESET;
      ref2_q <= `APD_REF_RESET;
    end else if (i_ce) begin
      if (wr_cfg) begin
        cfg_q  <= fr_q.word[11:0];
        stby_q <= fr_q.word[`APD_BIT_STANDBY];
      end
      if (frame_end) rdbk_q <= rd_cfg;
      if (wr_ref1) ref1_q <= fr_q.word[11:3];
      if (wr_ref2) ref2_q <= fr_q.word[11:3];
    end
  end

  // sampling restarts on every frame end in the active state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smp_q <= 1'b0;
    end else if (i_ce) begin
      smp_q <= frame_end && (state_q == apd_pkg::APD_ACTIVE);
    end
  end

  assign o_power_down             = pd_q;
  assign o_powering_up            = wake_q;
  assign o_sample_start           = smp_q;
  assign o_standby                = stby_q;
  assign o_range_double           = cfg_q[`APD_BIT_RANGE];
  assign o_neg_input_half         = cfg_q[`APD_BIT_NEG_INPUT];
  assign o_ref_internal_on        = cfg_q[`APD_BIT_REF_INT];
  assign o_first_reference_level  = ref1_q;
  assign o_second_reference_level = ref2_q;

  // ---------------- checks ----------------
  pd_entry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && active_end && go_down |=> pd_q && state_q == apd_pkg::APD_OFF)
    else $error("power-down not entered after high frame");
  wake_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && frame_end && state_q == apd_pkg::APD_OFF && go_up |=> wake_q && !pd_q)
    else $error("power-up not started after low frame");
  ref_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pd_q && $past(pd_q) |-> $stable(ref1_q) && $stable(ref2_q))
    else $error("reference level changed while powered down");
  abort_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && active_end && !frame_ok |=> $stable(cfg_q) && $stable(ref1_q))
    else $error("aborted frame changed a register");
  cfg_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_cfg && i_ce |=> cfg_q == $past(fr_q.word[11:0]))
    else $error("configuration write not applied");
  unknown_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take_word && !wr_cfg && !wr_ref1 && !wr_ref2 |=> $stable(cfg_q) && $stable(ref2_q))
    else $error("unknown command changed a register");
  sample_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && active_end |=> o_sample_start ##1 !o_sample_start || $past(frame_end))
    else $error("sample restart pulse missing");
  pd_hiz_a: assert property (@(negedge i_sclk) disable iff (link_clr)
    pd_s2_q |-> oe_a_n_q && oe_b_n_q)
    else $error("output driven while powered down");
  single_line_a: assert property (@(negedge i_sclk) disable iff (link_clr)
    sgl_s2_q |-> oe_b_n_q)
    else $error("second line driven in single-line mode");
  ref_first_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_ref1 |=> ref1_q == $past(fr_q.word[11:3]))
    else $error("first reference level not loaded");
  ref_second_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_ref2 |=> ref2_q == $past(fr_q.word[11:3]))
    else $error("second reference level not loaded");
  standby_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_cfg |=> o_standby == $past(fr_q.word[`APD_BIT_STANDBY]))
    else $error("standby command not followed");
  readback_arm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && rd_cfg |=> rdbk_q)
    else $error("read-back request not armed");
  off_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && frame_end && state_q == apd_pkg::APD_OFF |=> $stable(cfg_q) && $stable(ref1_q))
    else $error("register changed by a frame while powered down");
  off_no_sample_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && frame_end && state_q != apd_pkg::APD_ACTIVE |=> !o_sample_start)
    else $error("sampling restarted while not powered");
  power_excl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(o_power_down && o_powering_up))
    else $error("powered down and powering up at once");
endmodule

// ---- hdl/apd_pkg.sv ----
// types for the converter serial-frame control block
package apd_pkg;
  typedef enum logic [1:0] {APD_ACTIVE, APD_OFF, APD_WAKING} apd_state_t;
  // what one frame left behind when chip select rose
  typedef struct packed {
    logic [15:0] word;
    logic        reach_dual;
    logic        reach_single;
    logic        high_run;
    logic        low_run;
  } apd_frame_t;
endpackage

// ---- test/adc_power_down_and_config_frames_test.sv ----
// self-checking bench of the converter serial-frame control block
`timescale 1ns/1ns
`include "apd_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module adc_power_down_and_config_frames_test;
  localparam logic [15:0] RES_A = 16'hB3C5;
  localparam logic [15:0] RES_B = 16'h6A1E;
  logic        i_clk;
  logic        i_rst_n;
  logic        ce;
  logic [15:0] i_result_first;
  logic [15:0] i_result_second;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo1;
  logic        oe1_n;
  logic        sdo2;
  logic        oe2_n;
  logic        pd;
  logic        pu;
  logic        ss;
  logic        sb;
  logic        rd;
  logic        nh;
  logic        ri;
  logic [8:0]  ref1;
  logic [8:0]  ref2;
  wire         line1;
  wire         line2;
  int          bad_count;
  int          num_checks;
  int          cycles;
  int          starts;
  int          n;
  int          cnt;

  // released data lines show the inverse of the last bit
  assign line1 = oe1_n ? ~sdo1 : sdo1;
  assign line2 = oe2_n ? ~sdo2 : sdo2;

  apd_frame_ctrl i_dut (
    .i_clk                    (i_clk),
    .i_rst_n                  (i_rst_n),
    .i_ce                     (ce),
    .i_sclk                   (sclk),
    .i_cs_n                   (cs_n),
    .i_sdi                    (sdi),
    .i_result_first           (i_result_first),
    .i_result_second          (i_result_second),
    .o_serial_out_first       (sdo1),
    .o_serial_out_first_oe_n  (oe1_n),
    .o_serial_out_second      (sdo2),
    .o_serial_out_second_oe_n (oe2_n),
    .o_power_down             (pd),
    .o_powering_up            (pu),
    .o_sample_start           (ss),
    .o_standby                (sb),
    .o_range_double           (rd),
    .o_neg_input_half         (nh),
    .o_ref_internal_on        (ri),
    .o_first_reference_level  (ref1),
    .o_second_reference_level (ref2)
  );

  apd_host_model i_host (
    .i_line_first  (line1),
    .i_line_second (line2),
    .i_oe_first_n  (oe1_n),
    .i_oe_second_n (oe2_n),
    .o_cs_n        (cs_n),
    .o_sclk        (sclk),
    .o_sdi         (sdi)
  );

  // main clock, 8 ns period
  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;

  // counts sample-start pulses and cuts a hang short
  always @(posedge i_clk) begin
    cycles++;
    if (ss === 1'b1) starts++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // gathers 16 captured bits of one line starting at edge s
  function automatic logic [15:0] slot(input bit second, input int s);
    logic [15:0] v;
    for (int i = 0; i < 16; i++) v[15-i] = second ? i_host.cap2[s+i] : i_host.cap1[s+i];
    return v;
  endfunction

  // one frame, then room for the result to land
  task automatic frm(input logic [47:0] w, input int edges);
    i_host.frame(w, edges);
    repeat (8) @(posedge i_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence; only offsets 0 and 2 are written, configuration words keep bits 11 and 8 zero
  initial begin
    i_rst_n = 1'b0;
    ce = 1'b1;
    i_result_first = RES_A;
    i_result_second = RES_B;
    repeat (4) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    `CHK({ref1, ref2}, 18'h3FFFF)
    `CHK({pd, pu, rd, nh, ri, sb, oe1_n}, 7'h01)
    // dual-line configuration write
    frm({16'h82E0, 32'h0}, 32);
    `CHK({rd, nh, ri, sb}, 4'hF)
    `CHK(slot(0, 16), RES_A)
    `CHK(slot(1, 16), RES_B)
    `CHK(i_host.cap1[32], 1'b0)
    // short frame: write dropped, shifted bits still belong to the sample
    n = starts;
    frm({16'h8000, 32'h0}, 31);
    `CHK({rd, nh, ri, sb}, 4'hF)
    `CHK(slot(0, 15), RES_A >> 1)
    `CHK(starts, n + 1)
    // read back, then an undefined command
    frm({16'h3000, 32'h0}, 32);
    frm({16'h5000, 32'h0}, 32);
    `CHK(slot(0, 16), 16'h02C0)
    `CHK({rd, nh, ri, sb, ref1}, 13'h1FFF)
    // both reference levels
    frm({4'h9, 9'h0A5, 3'h0, 32'h0}, 32);
    frm({4'hA, 9'h15A, 3'h0, 32'h0}, 32);
    `CHK({ref1, ref2}, {9'h0A5, 9'h15A})
    // single-line mode with two's complement output
    frm({16'h8410, 32'h0}, 32);
    `CHK({rd, nh, ri, sb}, 4'h0)
    frm({16'h8200, 32'h0}, 32);
    `CHK(rd, 1'b0)
    // main domain frozen for a whole frame: the frame goes unseen
    n = starts;
    ce = 1'b0;
    frm({16'h8600, 32'h0}, 48);
    ce = 1'b1;
    `CHK(rd, 1'b0)
    `CHK(starts, n)
    frm(48'h0, 48);
    `CHK(slot(0, 16), RES_A ^ 16'h8000)
    `CHK(slot(0, 32), RES_B ^ 16'h8000)
    `CHK(i_host.drove2, 1'b0)
    // power-down entry and a held-high frame
    frm(48'hFFFF_FFFF_FFFF, 48);
    `CHK({pd, ref1, ref2}, {1'b1, 9'h0A5, 9'h15A})
    frm(48'hFFFF_FFFF_FFFF, 48);
    `CHK({i_host.drove1, i_host.drove2, pd}, 3'b001)
    // wake frame, then wait out the wake delay
    frm(48'h0, 48);
    `CHK({pd, pu}, 2'b01)
    cnt = 0;
    while (pu === 1'b1 && cnt < 1000) begin
      @(posedge i_clk);
      #1;
      cnt++;
    end
    `CHK(cnt >= `APD_WAKE_CYC - 20 && cnt <= `APD_WAKE_CYC, 1'b1)
    // first write after wake, its returned data ignored
    frm({16'h8200, 32'h0}, 48);
    `CHK({pd, pu, rd}, 3'b001)
    tally_and_finish();
  end
endmodule

// ---- test/apd_host_model.sv ----
// host controller model that drives serial frames into the converter block
`timescale 1ns/1ns
module apd_host_model (
  input  wire logic i_line_first,
  input  wire logic i_line_second,
  input  wire logic i_oe_first_n,
  input  wire logic i_oe_second_n,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  logic cap1 [1:48];
  logic cap2 [1:48];
  logic drove1;
  logic drove2;

  // idle: deselected, link clock parked high
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_sdi  = 1'b0;
  end

  // one frame of n falling edges, input msb first, 30 ns link clock inside the frame only
  task automatic frame(input logic [47:0] w, input int n);
    int k;
    drove1 = 1'b0;
    drove2 = 1'b0;
    o_cs_n = 1'b0;
    o_sdi  = w[47];
    #45;
    for (k = 1; k <= n; k++) begin
      o_sclk = 1'b0;
      #15;
      o_sclk = 1'b1;
      cap1[k] = i_line_first;
      cap2[k] = i_line_second;
      if (i_oe_first_n === 1'b0) drove1 = 1'b1;
      if (i_oe_second_n === 1'b0) drove2 = 1'b1;
      // input level held for whole frame when w is all ones or zeros
      o_sdi = (k < 48) ? w[47 - k] : o_sdi;
      #15;
    end
    o_cs_n = 1'b1;
    // released input shows the inverse of its last level
    o_sdi  = ~o_sdi;
    #45;
  endtask
endmodule
